/* File: shared/lpm_map.vh */
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
// ==========================================================
// register byte addresses
`define ADDR_CLK_CTRL_ZERO  12'h000
`define ADDR_CLK_CTRL_ONE   12'h004
`define ADDR_MAIN_CLK_DIV   12'h008
`define ADDR_EXIT_LEVEL     12'h00c
`define ADDR_PROTECT        12'h010
`define ADDR_STATUS         12'h014
// ==========================================================
// field positions
`define BIT_WAIT_PERIPH_STOP 2
`define BIT_MAIN_OSC_STOP    5
`define BIT_ALL_CLOCK_STOP   0
`define BIT_CLOCK_UNLOCK     0
`define BIT_SINGLE_UNLOCK    2
`define BIT_ST_WAIT          0
`define BIT_ST_STOP          1
`define BIT_ST_RUN           2
// ==========================================================
// reset values and constants
`define RST_CLK_CTRL_ZERO   8'h00
`define RST_CLK_CTRL_ONE    8'h00
`define RST_MAIN_CLK_DIV    5'h08
`define RST_EXIT_LEVEL      3'h0
`define RST_PROTECT         8'h00
`define DIV_BY_8            5'h08
`define LEVEL_MAX           3'h7
`endif

/* File: rtl/wake_qualifier.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// wake qualification by priority threshold
module wake_qualifier (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       irq_req,
  input  wire [2:0] irq_level,
  input  wire [2:0] threshold,
  input  wire       irq_enable,
  output reg        wake_r
);
  always @(posedge clk) begin
    if (rst) begin
      wake_r <= 1'b0;
    end else if (ce) begin
      wake_r <= irq_req & irq_enable & (irq_level > threshold);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/low_power_mode_control.v */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.vh"
module low_power_mode_control (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        halt_exec,
  input  wire        other_write,
  input  wire        irq_req,
  input  wire [2:0]  irq_level,
  input  wire        irq_enable,
  input  wire        low_speed_mode,
  output reg         cpu_run_r,
  output reg         main_periph_clk_en_r,
  output reg         subclock_periph_clk_en_r,
  output reg         main_osc_en_r,
  output reg         osc_output_pin_en_r,
  output reg         wake_service_r,
  output reg         port_hold_r,
  output reg  [4:0]  clk_div_r
);
  // ========================================================
  // state machine
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] clk_ctrl_zero_r;
  reg [7:0] clk_ctrl_one_r;
  reg [2:0] exit_level_r;
  reg [7:0] protect_r;
  wire      wake;

  function addr_hit;
    input [11:0] a;
    input [11:0] ref_a;
    begin
      addr_hit = (a == ref_a);
    end
  endfunction

  // registered answer: one wait state, pready high one cycle
  wire acc    = psel & penable & ~pready;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire mapped = addr_hit(paddr, `ADDR_CLK_CTRL_ZERO) |
                addr_hit(paddr, `ADDR_CLK_CTRL_ONE) |
                addr_hit(paddr, `ADDR_MAIN_CLK_DIV) |
                addr_hit(paddr, `ADDR_EXIT_LEVEL) |
                addr_hit(paddr, `ADDR_PROTECT) |
                addr_hit(paddr, `ADDR_STATUS);
  wire stop_req = wr_acc & addr_hit(paddr, `ADDR_CLK_CTRL_ONE) &
                  protect_r[`BIT_CLOCK_UNLOCK] &
                  pwdata[`BIT_ALL_CLOCK_STOP];

  // wake is registered, so exit lags the interrupt by one cycle
  wake_qualifier u_wake (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .irq_req    (irq_req),
    .irq_level  (irq_level),
    .threshold  (exit_level_r),
    .irq_enable (irq_enable),
    .wake_r     (wake)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_req) begin
          state_nxt = ST_STOP;
        end else if (halt_exec) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wake) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ========================================================
  // registers and bus
  always @(posedge clk) begin
    if (rst) begin
      state_r         <= ST_RUN;
      clk_ctrl_zero_r <= `RST_CLK_CTRL_ZERO;
      clk_ctrl_one_r  <= `RST_CLK_CTRL_ONE;
      clk_div_r       <= `RST_MAIN_CLK_DIV;
      exit_level_r    <= `RST_EXIT_LEVEL;
      protect_r       <= `RST_PROTECT;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      pready  <= acc;
      pslverr <= acc & ~mapped;
      // stop request bit reads back 1 only while stopped
      if (state_nxt != ST_STOP) begin
        clk_ctrl_one_r[`BIT_ALL_CLOCK_STOP] <= 1'b0;
      end
      // a write to the protect register itself wins over this clear
      if (other_write | wr_acc) begin
        protect_r[`BIT_SINGLE_UNLOCK] <= 1'b0;
      end
      if (wr_acc) begin
        if (addr_hit(paddr, `ADDR_CLK_CTRL_ZERO)) begin
          clk_ctrl_zero_r <= pwdata[7:0];
        end
        if (addr_hit(paddr, `ADDR_CLK_CTRL_ONE)) begin
          clk_ctrl_one_r[7:1] <= pwdata[7:1];
          if (stop_req) begin
            clk_ctrl_one_r[`BIT_ALL_CLOCK_STOP] <= 1'b1;
          end
        end
        if (addr_hit(paddr, `ADDR_MAIN_CLK_DIV)) begin
          clk_div_r <= pwdata[4:0];
        end
        if (addr_hit(paddr, `ADDR_EXIT_LEVEL)) begin
          exit_level_r <= pwdata[2:0];
        end
        if (addr_hit(paddr, `ADDR_PROTECT)) begin
          protect_r <= pwdata[7:0];
        end
      end
      if (stop_req) begin
        clk_div_r <= `DIV_BY_8;
      end
      prdata <= 32'h0000_0000;
      if (rd_acc) begin
        if (addr_hit(paddr, `ADDR_CLK_CTRL_ZERO)) begin
          prdata <= {24'h00_0000, clk_ctrl_zero_r};
        end
        if (addr_hit(paddr, `ADDR_CLK_CTRL_ONE)) begin
          prdata <= {24'h00_0000, clk_ctrl_one_r};
        end
        if (addr_hit(paddr, `ADDR_MAIN_CLK_DIV)) begin
          prdata <= {27'h000_0000, clk_div_r};
        end
        if (addr_hit(paddr, `ADDR_EXIT_LEVEL)) begin
          prdata <= {29'h0000_0000, exit_level_r};
        end
        if (addr_hit(paddr, `ADDR_PROTECT)) begin
          prdata <= {24'h00_0000, protect_r};
        end
        if (addr_hit(paddr, `ADDR_STATUS)) begin
          prdata <= {29'h0000_0000, state_r[0], state_r[2], state_r[1]};
        end
      end
    end
  end

  // ========================================================
  // clock gating, port hold and wake service outputs
  always @(posedge clk) begin
    if (rst) begin
      cpu_run_r                <= 1'b1;
      main_periph_clk_en_r     <= 1'b1;
      subclock_periph_clk_en_r <= 1'b1;
      main_osc_en_r            <= 1'b1;
      osc_output_pin_en_r      <= 1'b1;
      wake_service_r           <= 1'b0;
      port_hold_r              <= 1'b0;
    end else if (ce) begin
      // outputs except wake_service_r follow state_nxt so they switch with the state
      cpu_run_r <= (state_nxt == ST_RUN);
      // main-derived peripheral clocks off in wait when asked, always in stop
      main_periph_clk_en_r <= ~((state_nxt == ST_STOP) |
        ((state_nxt == ST_WAIT) &
         clk_ctrl_zero_r[`BIT_WAIT_PERIPH_STOP]));
      subclock_periph_clk_en_r <= (state_nxt != ST_STOP);
      main_osc_en_r <= ~clk_ctrl_zero_r[`BIT_MAIN_OSC_STOP] &
                       (state_nxt != ST_STOP);
      osc_output_pin_en_r <= ~clk_ctrl_zero_r[`BIT_MAIN_OSC_STOP] &
                             (state_nxt != ST_STOP);
      wake_service_r <= (state_r != ST_RUN) & wake;
      port_hold_r <= (state_nxt != ST_RUN);
    end
  end
endmodule
`default_nettype wire

/* File: tb/lpm_props.sv */
`timescale 1ns/1ps
`default_nettype none
module lpm_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       irq_req,
  input wire logic       cpu_run_r,
  input wire logic       port_hold_r,
  input wire logic       wake_service_r,
  input wire logic       main_osc_en_r,
  input wire logic       subclock_periph_clk_en_r,
  input wire logic [4:0] clk_div_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // bus answer
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // ==========
  // power modes
  sequence s_stop; $fell(subclock_periph_clk_en_r); endsequence
  sequence s_idle; (!cpu_run_r && !irq_req)[*4]; endsequence
  property p_div; s_stop |-> clk_div_r == 5'h08; endproperty
  a_div: assert property (p_div) else $error("divider not 8");
  property p_all; !subclock_periph_clk_en_r |-> !main_osc_en_r; endproperty
  a_all: assert property (p_all) else $error("osc runs in stop");
  property p_hold; !cpu_run_r |-> port_hold_r; endproperty
  a_hold: assert property (p_hold) else $error("ports not held");
  property p_nowake; s_idle |=> !cpu_run_r; endproperty
  a_nowake: assert property (p_nowake) else $error("woke alone");
  property p_svc; $rose(cpu_run_r) |-> wake_service_r; endproperty
  a_svc: assert property (p_svc) else $error("no service");
  property p_svc1; wake_service_r |=> !wake_service_r; endproperty
  a_svc1: assert property (p_svc1) else $error("service long");
endmodule
bind low_power_mode_control lpm_props lpm_props_i (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.vh"
module testbench;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        halt_exec = 0, other_write = 0, irq_req = 0, irq_enable = 0;
  logic        ce = 1, svc;
  logic        pready, pslverr, cpu_run_r, mp_en, sc_en, osc_en, pin, hold;
  logic [2:0]  irq_level = 0;
  logic [4:0]  clk_div_r;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'headd, t, d;
  logic [33:0] q[$];
  logic [33:0] e;
  int          n_mismatch = 0, samples_checked = 0;
  int          n_svc = 0;
  always #4 clk = ~clk;
  low_power_mode_control low_power_mode_control_i (.clk(clk), .rst(rst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_exec(halt_exec), .other_write(other_write),
    .irq_req(irq_req), .irq_level(irq_level), .irq_enable(irq_enable),
    .low_speed_mode(1'b0), .cpu_run_r(cpu_run_r),
    .main_periph_clk_en_r(mp_en), .subclock_periph_clk_en_r(sc_en),
    .main_osc_en_r(osc_en), .osc_output_pin_en_r(pin),
    .wake_service_r(svc), .port_hold_r(hold), .clk_div_r(clk_div_r));
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] a;
    a = v ^ (v << 13);
    a = a ^ (a >> 17);
    return a ^ (a << 5);
  endfunction
  task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [33:0] x);
    int i;
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++i < 50);
    if (i == 50) begin
      n_mismatch++;
      results;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, {2'b10, x});
  endtask
  task automatic wake(input int n);
    int i;
    for (i = 0; i < 20 && cpu_run_r !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    ck("cpu_run", 32'h1, cpu_run_r);
    ck("wake_service", n, n_svc);
    if (i == 20) begin
      n_mismatch++;
      results;
    end
  endtask
  always @(posedge clk) if (svc === 1'b1) n_svc++;
  always @(posedge clk) if (pready === 1'b1) begin
    if (q.size() == 0) begin
      n_mismatch++;
      $display("unexpected pready exp 0 got 1");
    end
    e = (q.size() > 0) ? q.pop_front() : 34'h0;
    ck("pslverr", e[32], pslverr);
    if (e[33]) ck("prdata", e[31:0], prdata);
  end
  // ==========
  // scenarios
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_CLK_CTRL_ZERO, `RST_CLK_CTRL_ZERO);
    rd(`ADDR_MAIN_CLK_DIV, `RST_MAIN_CLK_DIV);
    rd(`ADDR_EXIT_LEVEL, `RST_EXIT_LEVEL);
    rd(`ADDR_STATUS, 32'h4);
    bus(1'b0, 12'h018, 32'h0, {2'b11, 32'h0});
    bus(1'b1, 12'h018, 32'hffff_ffff, {2'b01, 32'h0});
    $display("reset test done");
    wr(`ADDR_EXIT_LEVEL, `LEVEL_MAX);
    wr(`ADDR_CLK_CTRL_ONE, 32'h1);
    rd(`ADDR_STATUS, 32'h4);
    rd(`ADDR_CLK_CTRL_ONE, 32'h0);
    seed = xs(seed);
    t = seed % 7;
    d = {27'h0, 1'b1, seed[7:4]};
    wr(`ADDR_PROTECT, 32'h4);
    other_write <= 1'b1;
    @(posedge clk);
    other_write <= 1'b0;
    rd(`ADDR_PROTECT, 32'h0);
    wr(`ADDR_PROTECT, 32'h4);
    wr(`ADDR_EXIT_LEVEL, t);
    rd(`ADDR_PROTECT, 32'h0);
    rd(`ADDR_EXIT_LEVEL, t);
    $display("protect test done");
    wr(`ADDR_MAIN_CLK_DIV, d);
    rd(`ADDR_MAIN_CLK_DIV, d);
    irq_level <= t[2:0];
    irq_enable <= 1'b1;
    wr(`ADDR_PROTECT, 32'h1);
    wr(`ADDR_CLK_CTRL_ONE, 32'h1);
    repeat (4) @(posedge clk);
    ck("clk_div", `DIV_BY_8, clk_div_r);
    ck("stop", 32'h0, {cpu_run_r, mp_en, sc_en, osc_en, pin});
    ck("port_hold", 32'h1, hold);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    ck("cpu_run", 32'h0, cpu_run_r);
    irq_level <= `LEVEL_MAX;
    wake(1);
    irq_req <= 1'b0;
    wr(`ADDR_EXIT_LEVEL, `LEVEL_MAX);
    rd(`ADDR_CLK_CTRL_ONE, 32'h0);
    $display("stop test done");
    wr(`ADDR_EXIT_LEVEL, t);
    wr(`ADDR_CLK_CTRL_ZERO, 32'h4);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    irq_enable <= 1'b0;
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    ck("cpu_run", 32'h0, cpu_run_r);
    ck("clocks", 32'h1, {mp_en, sc_en});
    ck("port_hold", 32'h1, hold);
    irq_enable <= 1'b1;
    wake(2);
    irq_req <= 1'b0;
    wr(`ADDR_EXIT_LEVEL, `LEVEL_MAX);
    $display("wait test done");
    wr(`ADDR_PROTECT, 32'h1);
    wr(`ADDR_CLK_CTRL_ONE, 32'h1);
    repeat (4) @(posedge clk);
    ck("stop", 32'h0, cpu_run_r);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ck("reset", 32'h3e, {cpu_run_r, mp_en, sc_en, osc_en, pin, hold});
    rd(`ADDR_STATUS, 32'h4);
    rd(`ADDR_PROTECT, `RST_PROTECT);
    rd(`ADDR_EXIT_LEVEL, `RST_EXIT_LEVEL);
    wr(`ADDR_EXIT_LEVEL, `LEVEL_MAX);
    $display("stop reset test done");
    wr(`ADDR_CLK_CTRL_ZERO, 32'h20);
    repeat (2) @(posedge clk);
    ck("osc", 32'h4, {cpu_run_r, osc_en, pin});
    $display("oscillator test done");
    ce <= 1'b0;
    halt_exec <= 1'b1;
    repeat (3) @(posedge clk);
    halt_exec <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    ck("frozen", 32'h2, {cpu_run_r, hold});
    rd(`ADDR_STATUS, 32'h4);
    $display("clock enable test done");
    results;
  end
endmodule
`default_nettype wire
